// ### rcr_pkg.sv
// Package for the regulator configuration register bank.
package rcr_pkg;
    // Register indices as printed (byte address = index * 4).
    localparam logic [7:0] IDX_BUCK1_PROT  = 8'h47;
    localparam logic [7:0] IDX_BUCK2_MODE  = 8'h48;
    localparam logic [7:0] IDX_BUCK2_PROT  = 8'h49;
    localparam logic [7:0] IDX_BUCK3_MODE  = 8'h4A;
    localparam logic [7:0] IDX_BUCK3_PROT  = 8'h4B;
    localparam logic [7:0] IDX_LIN0_VOLT   = 8'h50;
    localparam logic [7:0] IDX_LIN0_CTRL   = 8'h51;
    localparam logic [7:0] IDX_LIN1_VOLT   = 8'h52;
    localparam int         NUM_REGS        = 8;
    localparam int         ADDR_W          = 12;
    // Protection register fields.
    localparam int         BO_LEVEL_LSB    = 6;
    localparam int         BO_HYST_LSB     = 4;
    localparam int         BO_SPEED_LSB    = 1;
    localparam int         OV_LEVEL_BIT    = 0;
    // Mode register fields.
    localparam int         DIS_DISABLE_BIT = 1;
    localparam int         FPWM_BIT        = 0;
    // Linear regulator control fields.
    localparam int         CLAMP_BIT       = 7;
    localparam int         LOWPWR_BIT      = 6;
    localparam int         PGOOD_BIT       = 3;
    localparam int         DISCH_BIT       = 1;
    localparam int         RAMP_BIT        = 0;
    localparam int         VCODE_W         = 6;
    // Writable bit masks per register; the rest hold no state.
    localparam logic [7:0] MASK_PROT       = 8'hF7;
    localparam logic [7:0] MASK_MODE       = 8'h03;
    localparam logic [7:0] MASK_VOLT       = 8'h3F;
    localparam logic [7:0] MASK_CTRL       = 8'hC3;
    // Fixed reset of the buck1 and buck3 speed fields and the buck2 and buck3 forced-PWM bits.
    localparam logic [1:0] BO_SPEED_RST    = 2'h3;
    localparam logic       FPWM_RST        = 1'b0;
    localparam logic       LOWPWR_RST      = 1'b0;
    localparam logic       CLAMP_RST       = 1'b1;
    localparam logic [1:0] RESP_OKAY       = 2'h0;
    localparam logic [1:0] RESP_SLVERR     = 2'h2;
endpackage : rcr_pkg

// ### rcr_regs.sv
// AXI4-Lite register bank configuring three bucks and two linear regulators.
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module rcr_regs (
    input  wire logic                        clk_sys_i,
    input  wire logic                        srst_i,
    // AXI4-Lite slave.
    input  wire logic [rcr_pkg::ADDR_W-1:0]  s_axi_awaddr_i,
    input  wire logic                        s_axi_awvalid_i,
    output logic                             s_axi_awready_o,
    input  wire logic [31:0]                 s_axi_wdata_i,
    input  wire logic [3:0]                  s_axi_wstrb_i,
    input  wire logic                        s_axi_wvalid_i,
    output logic                             s_axi_wready_o,
    output logic [1:0]                       s_axi_bresp_o,
    output logic                             s_axi_bvalid_o,
    input  wire logic                        s_axi_bready_i,
    input  wire logic [rcr_pkg::ADDR_W-1:0]  s_axi_araddr_i,
    input  wire logic                        s_axi_arvalid_i,
    output logic                             s_axi_arready_o,
    output logic [31:0]                      s_axi_rdata_o,
    output logic [1:0]                       s_axi_rresp_o,
    output logic                             s_axi_rvalid_o,
    input  wire logic                        s_axi_rready_i,
    // Factory defaults, sampled on the first clock after reset is released.
    input  wire logic [63:0]                 otp_defaults_i,
    // Analog status and converter enables (asynchronous).
    input  wire logic                        linreg0_power_good_i,
    input  wire logic [2:0]                  buck_enabled_i,
    input  wire logic                        linreg0_enabled_i,
    // Configuration to the analog blocks.
    output logic [5:0]                       buck_brownout_level_o,
    output logic [5:0]                       buck_brownout_hysteresis_o,
    output logic [5:0]                       buck_brownout_speed_o,
    output logic [2:0]                       buck_overvoltage_level_o,
    output logic [1:0]                       buck_forced_pwm_o,
    output logic [1:0]                       buck_discharge_on_o,
    output logic [5:0]                       linreg0_voltage_code_o,
    output logic [5:0]                       linreg1_voltage_code_o,
    output logic                             linreg0_clamp_enable_o,
    output logic                             linreg0_auto_lowpower_o,
    output logic                             linreg0_discharge_on_o,
    output logic                             linreg0_ramp_select_o
);
    import rcr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers.

    function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
        reg_index = a[9:2];
    endfunction : reg_index

    // Slot number 0..7 of a register index, or NUM_REGS when unmapped.
    function automatic logic [3:0] slot_of(input logic [7:0] idx);
        if (idx == IDX_BUCK1_PROT) slot_of = 4'h0;
        else if (idx == IDX_BUCK2_MODE) slot_of = 4'h1;
        else if (idx == IDX_BUCK2_PROT) slot_of = 4'h2;
        else if (idx == IDX_BUCK3_MODE) slot_of = 4'h3;
        else if (idx == IDX_BUCK3_PROT) slot_of = 4'h4;
        else if (idx == IDX_LIN0_VOLT) slot_of = 4'h5;
        else if (idx == IDX_LIN0_CTRL) slot_of = 4'h6;
        else if (idx == IDX_LIN1_VOLT) slot_of = 4'h7;
        else slot_of = 4'h8;
    endfunction : slot_of

    localparam logic [7:0] SLOT_MASK [NUM_REGS] = '{MASK_PROT, MASK_MODE,
        MASK_PROT, MASK_MODE, MASK_PROT, MASK_VOLT, MASK_CTRL, MASK_VOLT};

    ////////////////////////////////////////////////////////////////////////
    // Register storage, one byte per slot, masked to its real bits.

    logic [7:0] regs      [NUM_REGS];
    logic [7:0] next_regs [NUM_REGS];
    logic       otp_loaded;
    logic       next_otp_loaded;

    // Write path state.
    logic                awr_hold;
    logic [ADDR_W-1:0]   awr_addr;
    logic                wr_hold;
    logic [7:0]          wr_byte;
    logic                wr_lane0;
    logic                next_awr_hold;
    logic [ADDR_W-1:0]   next_awr_addr;
    logic                next_wr_hold;
    logic [7:0]          next_wr_byte;
    logic                next_wr_lane0;
    logic                next_bvalid;
    logic [1:0]          next_bresp;
    logic [3:0]          wr_slot;

    // Factory default byte for each slot, fixed fields forced afterwards.
    function automatic logic [7:0] reset_value(input int s,
                                               input logic [63:0] otp);
        logic [7:0] v;
        v = otp[s*8 +: 8] & SLOT_MASK[s];
        if (s == 0 || s == 4)
            v[BO_SPEED_LSB +: 2] = BO_SPEED_RST;
        if (s == 1 || s == 3)
            v[FPWM_BIT] = FPWM_RST;
        reset_value = v;
    endfunction : reset_value

    always_comb begin
        next_otp_loaded = 1'b1;
        next_awr_hold   = awr_hold;
        next_awr_addr   = awr_addr;
        next_wr_hold    = wr_hold;
        next_wr_byte    = wr_byte;
        next_wr_lane0   = wr_lane0;
        next_bvalid     = s_axi_bvalid_o;
        next_bresp      = s_axi_bresp_o;
        wr_slot         = slot_of(reg_index(awr_addr));
        next_regs       = regs;
        if (!otp_loaded) begin
            // First cycle after reset release latches factory values.
            for (int s = 0; s < NUM_REGS; s++) begin
                next_regs[s] = reset_value(s, otp_defaults_i);
            end
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                next_awr_hold = 1'b1;
                next_awr_addr = s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                next_wr_hold  = 1'b1;
                next_wr_byte  = s_axi_wdata_i[7:0];
                next_wr_lane0 = s_axi_wstrb_i[0];
            end
            if (awr_hold && wr_hold && !s_axi_bvalid_o) begin
                next_awr_hold = 1'b0;
                next_wr_hold  = 1'b0;
                next_bvalid   = 1'b1;
                if (wr_slot == 4'h8) begin
                    next_bresp = RESP_SLVERR;
                end else begin
                    next_bresp = RESP_OKAY;
                    // Unbacked and status bits are dropped by the mask.
                    if (wr_lane0)
                        next_regs[wr_slot[2:0]] =
                            wr_byte & SLOT_MASK[wr_slot[2:0]];
                end
            end
            if (s_axi_bvalid_o && s_axi_bready_i)
                next_bvalid = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            regs            <= '{default: 8'h00};
            otp_loaded      <= 1'b0;
            awr_hold        <= 1'b0;
            awr_addr        <= '0;
            wr_hold         <= 1'b0;
            wr_byte         <= 8'h00;
            wr_lane0        <= 1'b0;
            s_axi_bvalid_o  <= 1'b0;
            s_axi_bresp_o   <= RESP_OKAY;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o  <= 1'b0;
        end else begin
            regs            <= next_regs;
            otp_loaded      <= next_otp_loaded;
            awr_hold        <= next_awr_hold;
            awr_addr        <= next_awr_addr;
            wr_hold         <= next_wr_hold;
            wr_byte         <= next_wr_byte;
            wr_lane0        <= next_wr_lane0;
            s_axi_bvalid_o  <= next_bvalid;
            s_axi_bresp_o   <= next_bresp;
            // Readies stay low while a write is held or answered.
            s_axi_awready_o <= !next_awr_hold && !next_bvalid;
            s_axi_wready_o  <= !next_wr_hold && !next_bvalid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status synchronisers.

    logic [4:0] status_sync;

    rcr_sync #(.WIDTH(5)) u_sync (
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .async_i   ({linreg0_power_good_i, linreg0_enabled_i,
                     buck_enabled_i}),
        .sync_o    (status_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read path.

    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;
    logic        next_rvalid;
    logic [3:0]  rd_slot;

    always_comb begin
        next_rdata  = s_axi_rdata_o;
        next_rresp  = s_axi_rresp_o;
        next_rvalid = s_axi_rvalid_o;
        rd_slot     = slot_of(reg_index(s_axi_araddr_i));
        if (s_axi_arvalid_i && s_axi_arready_o) begin
            next_rvalid = 1'b1;
            if (rd_slot == 4'h8) begin
                next_rdata = 32'h0000_0000;
                next_rresp = RESP_SLVERR;
            end else begin
                // Reserved and unbacked bits read as zero.
                next_rdata = {24'h00_0000, regs[rd_slot[2:0]]};
                next_rresp = RESP_OKAY;
                if (rd_slot == 4'h6)
                    next_rdata[PGOOD_BIT] = status_sync[4];
            end
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            s_axi_rdata_o  <= 32'h0000_0000;
            s_axi_rresp_o  <= RESP_OKAY;
            s_axi_rvalid_o <= 1'b0;
            s_axi_arready_o <= 1'b0;
        end else begin
            s_axi_rdata_o  <= next_rdata;
            s_axi_rresp_o  <= next_rresp;
            s_axi_rvalid_o <= next_rvalid;
            s_axi_arready_o <= !next_rvalid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration outputs; the analog side decodes each code.

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            buck_brownout_level_o      <= 6'h00;
            buck_brownout_hysteresis_o <= 6'h00;
            buck_brownout_speed_o      <= 6'h00;
            buck_overvoltage_level_o   <= 3'h0;
            buck_forced_pwm_o          <= 2'h0;
            buck_discharge_on_o        <= 2'h0;
            linreg0_voltage_code_o     <= 6'h00;
            linreg1_voltage_code_o     <= 6'h00;
            linreg0_clamp_enable_o     <= CLAMP_RST;
            linreg0_auto_lowpower_o    <= LOWPWR_RST;
            linreg0_discharge_on_o     <= 1'b0;
            linreg0_ramp_select_o      <= 1'b0;
        end else begin
            for (int b = 0; b < 3; b++) begin
                buck_brownout_level_o[b*2 +: 2] <=
                    regs[b*2][BO_LEVEL_LSB +: 2];
                buck_brownout_hysteresis_o[b*2 +: 2] <=
                    regs[b*2][BO_HYST_LSB +: 2];
                buck_brownout_speed_o[b*2 +: 2] <=
                    regs[b*2][BO_SPEED_LSB +: 2];
                buck_overvoltage_level_o[b] <=
                    regs[b*2][OV_LEVEL_BIT];
            end
            for (int m = 0; m < 2; m++) begin
                buck_forced_pwm_o[m] <= regs[m*2+1][FPWM_BIT];
                // Resistor only on a stopped buck whose disable bit is 0.
                buck_discharge_on_o[m] <= !regs[m*2+1][DIS_DISABLE_BIT]
                    && !status_sync[m+1];
            end
            linreg0_voltage_code_o  <= regs[5][VCODE_W-1:0];
            linreg1_voltage_code_o  <= regs[7][VCODE_W-1:0];
            linreg0_clamp_enable_o  <= regs[6][CLAMP_BIT];
            linreg0_auto_lowpower_o <= regs[6][LOWPWR_BIT];
            linreg0_discharge_on_o  <= regs[6][DISCH_BIT]
                && !status_sync[3];
            linreg0_ramp_select_o   <= regs[6][RAMP_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    a_write_store: assert property (@(posedge clk_sys_i)
        disable iff (srst_i) (otp_loaded && awr_hold && wr_hold
        && !s_axi_bvalid_o && wr_lane0 && wr_slot == 4'h6)
        |=> (regs[6] == ($past(wr_byte) & MASK_CTRL)))
        else $error("Control register did not store masked write.");
    a_mode_upper: assert property (@(posedge clk_sys_i)
        disable iff (srst_i) otp_loaded |-> regs[3][7:4] == 4'h0)
        else $error("Buck3 mode upper bits hold state.");
    a_clamp_out: assert property (@(posedge clk_sys_i)
        disable iff (srst_i)
        otp_loaded |=> linreg0_clamp_enable_o == $past(regs[6][CLAMP_BIT]))
        else $error("Clamp enable does not follow register.");
    a_pgood_read: assert property (@(posedge clk_sys_i)
        disable iff (srst_i) (s_axi_arvalid_i && s_axi_arready_o
        && rd_slot == 4'h6)
        |=> s_axi_rdata_o[PGOOD_BIT] == $past(status_sync[4]))
        else $error("Power-good read does not match status.");
    a_buck_disch: assert property (@(posedge clk_sys_i)
        disable iff (srst_i)
        ##1 (regs[1][DIS_DISABLE_BIT] && $past(regs[1][DIS_DISABLE_BIT]))
        |-> !buck_discharge_on_o[0])
        else $error("Discharge applied while disabled by software.");
    a_lin_disch: assert property (@(posedge clk_sys_i)
        disable iff (srst_i) (otp_loaded && status_sync[3])
        |=> !linreg0_discharge_on_o)
        else $error("Linear discharge on while regulator enabled.");
    a_level_out: assert property (@(posedge clk_sys_i)
        disable iff (srst_i) otp_loaded |=> buck_brownout_level_o[1:0]
            == $past(regs[0][BO_LEVEL_LSB +: 2]))
        else $error("Brownout level does not follow register.");
    a_speed_rst: assert property (@(posedge clk_sys_i)
        $fell(srst_i) ##1 1'b1 |-> regs[0][BO_SPEED_LSB +: 2] == BO_SPEED_RST
        && regs[4][BO_SPEED_LSB +: 2] == BO_SPEED_RST)
        else $error("Buck speed fields did not reset to slow.");
    a_vcode_out: assert property (@(posedge clk_sys_i)
        disable iff (srst_i)
        otp_loaded |=> linreg1_voltage_code_o == $past(regs[7][5:0]))
        else $error("Linear voltage code does not follow register.");
endmodule : rcr_regs
`default_nettype wire

// ### rcr_regs_note_end.sv
// Companion unit of the register bank; it holds no logic of its own.

// ### rcr_sync.sv
// Two-flop synchroniser for level inputs from outside the clock domain.
`timescale 1ns/10ps
`default_nettype none
module rcr_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys_i,
    input  wire logic             srst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync;

    always_comb begin
        next_stage1 = async_i;
        next_sync   = stage1;
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            stage1 <= '0;
            sync_o <= '0;
        end else begin
            stage1 <= next_stage1;
            sync_o <= next_sync;
        end
    end
endmodule : rcr_sync
`default_nettype wire

// ### regulator_config_registers_tb.sv
// Self-checking bench for the regulator configuration register bank.
`timescale 1ns/10ps
`default_nettype none
module regulator_config_registers_tb;
    import rcr_pkg::*;
    logic              clk_sys_i, srst_i;
    logic [ADDR_W-1:0] s_axi_awaddr_i, s_axi_araddr_i;
    logic [31:0]       s_axi_wdata_i, s_axi_rdata_o;
    logic [3:0]        s_axi_wstrb_i;
    logic [1:0]        s_axi_bresp_o, s_axi_rresp_o;
    logic              s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i;
    logic              s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i;
    logic              s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o;
    logic              s_axi_rready_i, linreg0_power_good_i;
    logic              linreg0_enabled_i;
    logic [63:0]       otp_defaults_i;
    logic [2:0]        buck_enabled_i, buck_overvoltage_level_o;
    logic [5:0]        buck_brownout_level_o, buck_brownout_hysteresis_o;
    logic [5:0]        buck_brownout_speed_o, linreg0_voltage_code_o;
    logic [5:0]        linreg1_voltage_code_o;
    logic [1:0]        buck_forced_pwm_o, buck_discharge_on_o;
    logic              linreg0_clamp_enable_o, linreg0_auto_lowpower_o;
    logic              linreg0_discharge_on_o, linreg0_ramp_select_o;
    logic [7:0]        shadow [8];
    int                errors, n_compared;
    localparam logic [7:0] IDX [8] = '{IDX_BUCK1_PROT, IDX_BUCK2_MODE,
        IDX_BUCK2_PROT, IDX_BUCK3_MODE, IDX_BUCK3_PROT, IDX_LIN0_VOLT,
        IDX_LIN0_CTRL, IDX_LIN1_VOLT};
    localparam logic [7:0] MSK [8] = '{MASK_PROT, MASK_MODE, MASK_PROT,
        MASK_MODE, MASK_PROT, MASK_VOLT, MASK_CTRL, MASK_VOLT};
    localparam logic [7:0] BAD [3] = '{8'h46, 8'h4C, 8'h53};

    rcr_regs dut (
        .clk_sys_i, .srst_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
        .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
        .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
        .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
        .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
        .otp_defaults_i, .linreg0_power_good_i, .buck_enabled_i,
        .linreg0_enabled_i, .buck_brownout_level_o,
        .buck_brownout_hysteresis_o, .buck_brownout_speed_o,
        .buck_overvoltage_level_o, .buck_forced_pwm_o, .buck_discharge_on_o,
        .linreg0_voltage_code_o, .linreg1_voltage_code_o,
        .linreg0_clamp_enable_o, .linreg0_auto_lowpower_o,
        .linreg0_discharge_on_o, .linreg0_ramp_select_o
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic chk_resp(string what, logic [1:0] exp, logic [1:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk_resp

    // Address and data go out together; each is dropped at its own handshake.
    task automatic axi_wr(logic [7:0] idx, logic [31:0] d, logic [3:0] st,
                          output logic [1:0] r);
        int n = 0;
        bit done = 0;
        @(posedge clk_sys_i);
        s_axi_awaddr_i  <= {2'b00, idx, 2'b00};
        s_axi_awvalid_i <= 1'b1;
        s_axi_wdata_i   <= d;
        s_axi_wstrb_i   <= st;
        s_axi_wvalid_i  <= 1'b1;
        s_axi_bready_i  <= 1'b1;
        r = 2'h1;
        do begin
            @(posedge clk_sys_i);
            n++;
            if (s_axi_awvalid_i && s_axi_awready_o === 1'b1)
                s_axi_awvalid_i <= 1'b0;
            if (s_axi_wvalid_i && s_axi_wready_o === 1'b1)
                s_axi_wvalid_i <= 1'b0;
            if (s_axi_bvalid_o === 1'b1) begin
                r = s_axi_bresp_o;
                s_axi_bready_i <= 1'b0;
                done = 1;
            end
        end while (!done && n < 200);
    endtask : axi_wr

    task automatic axi_rd(logic [7:0] idx, output logic [1:0] r,
                          output logic [31:0] d);
        int n = 0;
        bit done = 0;
        @(posedge clk_sys_i);
        s_axi_araddr_i  <= {2'b00, idx, 2'b00};
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i  <= 1'b1;
        r = 2'h1;
        d = 32'h0;
        do begin
            @(posedge clk_sys_i);
            n++;
            if (s_axi_arvalid_i && s_axi_arready_o === 1'b1)
                s_axi_arvalid_i <= 1'b0;
            if (s_axi_rvalid_o === 1'b1) begin
                r = s_axi_rresp_o;
                d = s_axi_rdata_o;
                s_axi_rready_i <= 1'b0;
                done = 1;
            end
        end while (!done && n < 200);
    endtask : axi_rd

    // The power-good bit is live status, so it comes from the input level.
    function automatic logic [31:0] exp_rd(int s);
        exp_rd = {24'h0, shadow[s]};
        if (s == 6)
            exp_rd[PGOOD_BIT] = linreg0_power_good_i;
    endfunction : exp_rd

    task automatic rd_chk(int s);
        logic [1:0]  r;
        logic [31:0] d;
        axi_rd(IDX[s], r, d);
        chk_resp("read response", RESP_OKAY, r);
        chk("read data", exp_rd(s), d);
    endtask : rd_chk

    task automatic chk_out();
        chk("brownout fields", {14'h0, shadow[4][7:6], shadow[2][7:6],
            shadow[0][7:6], shadow[4][5:4], shadow[2][5:4], shadow[0][5:4],
            shadow[4][2:1], shadow[2][2:1], shadow[0][2:1]},
            {14'h0, buck_brownout_level_o, buck_brownout_hysteresis_o,
            buck_brownout_speed_o});
        chk("buck modes", {25'h0, shadow[4][0], shadow[2][0], shadow[0][0],
            shadow[3][0], shadow[1][0], ~shadow[3][1] & ~buck_enabled_i[2],
            ~shadow[1][1] & ~buck_enabled_i[1]}, {25'h0,
            buck_overvoltage_level_o, buck_forced_pwm_o,
            buck_discharge_on_o});
        chk("linear fields", {16'h0, shadow[5][5:0], shadow[7][5:0],
            shadow[6][7:6], shadow[6][1] & ~linreg0_enabled_i, shadow[6][0]},
            {16'h0, linreg0_voltage_code_o, linreg1_voltage_code_o,
            linreg0_clamp_enable_o, linreg0_auto_lowpower_o,
            linreg0_discharge_on_o,
            linreg0_ramp_select_o});
    endtask : chk_out

    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    // A full run takes about 1000 cycles, so this ceiling only cuts hangs.
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        errors++;
        $display("unexpected run length: expected end, seen timeout");
        give_verdict();
    end

    initial begin
        logic [1:0]  r;
        logic [31:0] d;
        logic [3:0]  st;
        int          s;
        void'($urandom(32'h63801F05));
        srst_i <= 1'b1;
        s_axi_awaddr_i <= '0;
        s_axi_araddr_i <= '0;
        s_axi_wdata_i <= 32'h0;
        s_axi_wstrb_i <= 4'h0;
        {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h0;
        {s_axi_arvalid_i, s_axi_rready_i} <= 2'h0;
        otp_defaults_i <= {$urandom, $urandom};
        buck_enabled_i <= 3'($urandom);
        linreg0_enabled_i <= 1'($urandom);
        linreg0_power_good_i <= 1'($urandom);
        repeat (8) @(posedge clk_sys_i);
        chk("clamp in reset", 32'h1, {31'h0, linreg0_clamp_enable_o});
        repeat (8) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        for (s = 0; s < 8; s++)
            shadow[s] = otp_defaults_i[8*s +: 8] & MSK[s];
        shadow[0][2:1] = BO_SPEED_RST;
        shadow[4][2:1] = BO_SPEED_RST;
        shadow[1][0] = FPWM_RST;
        shadow[3][0] = FPWM_RST;
        for (s = 0; s < 8; s++)
            rd_chk(s);
        chk_out();
        // All ones then all zeros to every slot first, then random traffic.
        for (int i = 0; i < 64; i++) begin
            s = (i < 16) ? i % 8 : $urandom_range(7);
            d = (i < 8) ? 32'hFFFFFFFF : (i < 16) ? 32'h0 : $urandom;
            // Reserved bits of the low byte go out as zero; buck3's unbacked nibble is
            // left unmasked on purpose to show that it stores nothing.
            d[7:0] = d[7:0] & (MSK[s] | ((s == 3) ? 8'hF0 : 8'h00));
            st = (i % 5 == 4) ? 4'hE : 4'hF;
            buck_enabled_i <= 3'($urandom);
            linreg0_enabled_i <= 1'($urandom);
            linreg0_power_good_i <= 1'($urandom);
            repeat (4) @(posedge clk_sys_i);
            axi_wr(IDX[s], d, st, r);
            chk_resp("write response", RESP_OKAY, r);
            if (st[0])
                shadow[s] = d[7:0] & MSK[s];
            rd_chk(s);
            repeat (3) @(posedge clk_sys_i);
            chk_out();
        end
        foreach (BAD[k]) begin
            axi_wr(BAD[k], 32'hFF, 4'hF, r);
            chk_resp("unmapped write", RESP_SLVERR, r);
            axi_rd(BAD[k], r, d);
            chk_resp("unmapped read", RESP_SLVERR, r);
            chk("unmapped data", 32'h0, d);
        end
        for (s = 0; s < 8; s++)
            rd_chk(s);
        give_verdict();
    end
endmodule : regulator_config_registers_tb
`default_nettype wire
